//--- rtl/grc_converter.sv
`timescale 1ns/1ns
// Notes on behaviour
// - convert byte mac signalling to nibble ddr both ways
// - work at 10, 100 and 1000 Mbps
// - change line rate while running, no reset
// - transmit pipeline of 0 to 10 stages
// - receive pipeline of 0 to 10 stages
// - no internal clock-to-data skew added
// - take mac transmit clock, return transmit clock
// - drive receive clock to mac from phy clock
// - transmit: byte, enable, error in; nibble, ctl out
// - receive: nibble, ctl in; byte, valid, error out
// - drive collision and carrier sense to mac
// - transmit timing from mac clock or references
// - receive logic timed by phy receive clock
// - decode in-band link and duplex status for collision
module grc_converter
    import grc_pkg::*;
#(
    parameter int TX_PIPELINE_DEPTH = DEF_PIPE_DEPTH,
    parameter int RX_PIPELINE_DEPTH = DEF_PIPE_DEPTH
) (
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire logic i_mac_tx_clock,
    input wire logic i_ref_clock_hundred_mbps,
    input wire logic i_ref_clock_ten_mbps,
    input wire logic i_mac_tx_rst_n,
    input wire logic i_mac_rx_rst_n,
    input wire logic [7:0] i_mac_txd,
    input wire logic i_mac_tx_en,
    input wire logic i_mac_tx_err,
    input wire logic [1:0] i_mac_speed,
    input wire logic i_rgmii_rx_clock,
    input wire logic [3:0] i_rgmii_rxd,
    input wire logic i_rgmii_rx_ctl,
    output logic o_mac_tx_clock_return,
    output logic o_mac_rx_clock,
    output logic [7:0] o_mac_rxd,
    output logic o_mac_rx_dv,
    output logic o_mac_rx_err,
    output logic o_mac_col,
    output logic o_mac_crs,
    output logic o_rgmii_tx_clock,
    output logic [3:0] o_rgmii_txd,
    output logic o_rgmii_tx_ctl
);
    // refuse pipeline depths beyond the documented range
    if (TX_PIPELINE_DEPTH > MAX_PIPE_DEPTH ||
        RX_PIPELINE_DEPTH > MAX_PIPE_DEPTH) begin : g_bad_param
        $error("pipeline depth above ten");
    end

    // all pins but the system clock and reset bundled for the two-flop synchroniser
    localparam int CTL_W = 13;
    localparam int DAT_W = BYTE_W + 2;
    localparam int RXB_W = BYTE_W + 2;

    logic [CTL_W-1:0] ctl_pins; // clocks, resets, speed, receive pins
    logic [CTL_W-1:0] ctl_meta; // first stage, read only by ctl_sync
    logic [CTL_W-1:0] ctl_sync; // safe copy
    logic [DAT_W-1:0] dat_pins; // transmit byte, enable, error
    logic [DAT_W-1:0] dat_meta; // first stage, read only by dat_sync
    logic [DAT_W-1:0] dat_sync; // safe copy

    assign ctl_pins = {i_mac_tx_clock, i_ref_clock_hundred_mbps,
                       i_ref_clock_ten_mbps, i_mac_tx_rst_n,
                       i_mac_rx_rst_n, i_mac_speed, i_rgmii_rx_clock,
                       i_rgmii_rxd, i_rgmii_rx_ctl};
    assign dat_pins = {i_mac_txd, i_mac_tx_en, i_mac_tx_err};

    // two flip-flops before any logic looks at a pin other than the system reset
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            ctl_meta <= '0;
            ctl_sync <= '0;
            dat_meta <= '0;
            dat_sync <= '0;
        end else begin
            ctl_meta <= ctl_pins;
            ctl_sync <= ctl_meta;
            dat_meta <= dat_pins;
            dat_sync <= dat_meta;
        end
    end

    // named views of the synchronised pins
    logic gig_ref_lvl; // mac transmit clock, used at 1000 Mbps
    logic hun_ref_lvl; // 25 MHz reference
    logic ten_ref_lvl; // 2.5 MHz reference
    logic tx_rst; // transmit side held in reset
    logic rx_rst; // receive side held in reset
    logic [1:0] speed; // current line rate code
    logic rx_clk_lvl; // phy receive clock level
    logic [3:0] rx_nib; // receive nibble
    logic rx_ctl; // receive control line

    // separate domain resets from the mac, plus the system reset
    assign tx_rst = i_srst | ~ctl_sync[9];
    assign rx_rst = i_srst | ~ctl_sync[8];
    assign gig_ref_lvl = ctl_sync[12];
    assign hun_ref_lvl = ctl_sync[11];
    assign ten_ref_lvl = ctl_sync[10];
    assign speed = ctl_sync[7:6]; // driven by the mac
    assign rx_clk_lvl = ctl_sync[5];
    assign rx_nib = ctl_sync[4:1];
    assign rx_ctl = ctl_sync[0];

    // wanted reference for the current speed code
    grc_ref_t want_ref;

    always_comb begin
        case (speed)
            SPEED_GIG: want_ref = REF_GIG;
            SPEED_HUNDRED: want_ref = REF_HUNDRED;
            default: want_ref = REF_TEN; // ten and the unused code
        endcase
    end

    // level of any reference
    function automatic logic ref_level(input grc_ref_t r, input logic g,
                                       input logic h, input logic t);
        case (r)
            REF_GIG: ref_level = g;
            REF_HUNDRED: ref_level = h;
            default: ref_level = t;
        endcase
    endfunction : ref_level

    // clock switch: park low on the old source, resume on a low of the new
    grc_sw_t sw_state; // switch state
    grc_ref_t active_ref; // reference currently driving the clock
    logic act_lvl; // level of the active reference
    logic want_lvl; // level of the wanted reference

    assign act_lvl = ref_level(active_ref, gig_ref_lvl, hun_ref_lvl,
                               ten_ref_lvl);
    assign want_lvl = ref_level(want_ref, gig_ref_lvl, hun_ref_lvl,
                                ten_ref_lvl);

    // parking on a low of the old level and resuming on a low of the new keeps every pulse whole
    always_ff @(posedge i_mclk) begin
        if (tx_rst) begin
            sw_state <= SW_PARK;
            active_ref <= REF_TEN;
        end else begin
            case (sw_state)
                SW_RUN: begin
                    if (want_ref != active_ref && !act_lvl) begin
                        sw_state <= SW_PARK;
                    end
                end
                SW_PARK: begin
                    if (!want_lvl) begin
                        active_ref <= want_ref; // live change
                        sw_state <= SW_RUN;
                    end
                end
                default: sw_state <= SW_PARK;
            endcase
        end
    end

    // next transmit clock level; held low while parked
    logic next_tx_clock;
    logic tx_rise; // transmit clock goes high this cycle
    logic tx_fall; // transmit clock goes low this cycle

    assign next_tx_clock = (sw_state == SW_RUN) & act_lvl;
    assign tx_rise = next_tx_clock & ~o_rgmii_tx_clock;
    assign tx_fall = ~next_tx_clock & o_rgmii_tx_clock;

    // clock to the phy and the copy returned to the mac
    always_ff @(posedge i_mclk) begin
        if (tx_rst) begin
            o_rgmii_tx_clock <= 1'b0;
            o_mac_tx_clock_return <= 1'b0;
        end else begin
            o_rgmii_tx_clock <= next_tx_clock;
            o_mac_tx_clock_return <= next_tx_clock;
        end
    end

    // optional transmit pipeline between mac and output stage
    logic [DAT_W-1:0] tx_piped;

    grc_pipe #(
        .WIDTH(DAT_W),
        .DEPTH(TX_PIPELINE_DEPTH)
    ) u_tx_pipe (
        .i_mclk(i_mclk),
        .i_srst(tx_rst),
        .i_data(dat_sync),
        .o_data(tx_piped)
    );

    logic [3:0] tx_hi_nib; // nibble for the falling half
    logic tx_fall_ctl; // control value for the falling half
    logic tx_en_live; // transmit enable seen on the wire, for collisions

    // data moves on the same cycle as the clock edge: no added skew
    always_ff @(posedge i_mclk) begin
        if (tx_rst) begin
            o_rgmii_txd <= NIBBLE_RST;
            o_rgmii_tx_ctl <= 1'b0;
            tx_hi_nib <= NIBBLE_RST;
            tx_fall_ctl <= 1'b0;
            tx_en_live <= 1'b0;
        end else if (tx_rise) begin
            // low nibble and enable on the rising half
            o_rgmii_txd <= tx_piped[5:2];
            o_rgmii_tx_ctl <= tx_piped[1];
            tx_en_live <= tx_piped[1];
            tx_fall_ctl <= tx_piped[1] ^ tx_piped[0];
            if (active_ref == REF_GIG) begin
                tx_hi_nib <= tx_piped[9:6];
            end else begin
                // mii rates repeat the single nibble on both halves
                tx_hi_nib <= tx_piped[5:2];
            end
        end else if (tx_fall) begin
            // high nibble and enable xor error on the falling half
            o_rgmii_txd <= tx_hi_nib;
            o_rgmii_tx_ctl <= tx_fall_ctl;
        end
    end

    // receive edge detection on the phy clock
    logic rx_clk_prev; // last sampled receive clock level
    logic rx_rise; // receive clock rose
    logic rx_fall; // receive clock fell

    assign rx_rise = rx_clk_lvl & ~rx_clk_prev;
    assign rx_fall = ~rx_clk_lvl & rx_clk_prev;

    logic [3:0] rx_lo_nib; // nibble of the rising half
    logic rx_ctl_rise; // control of the rising half
    logic [RXB_W-1:0] rx_word; // byte, valid, error after the falling half
    logic [3:0] inband; // last in-band status nibble
    logic rx_carrier; // carrier seen on the line

    // pair the two halves of each receive clock into one byte; mii rates take only the rising-half nibble
    always_ff @(posedge i_mclk) begin
        if (rx_rst) begin
            rx_clk_prev <= 1'b0;
            rx_lo_nib <= NIBBLE_RST;
            rx_ctl_rise <= 1'b0;
            rx_word <= '0;
            inband <= NIBBLE_RST;
            rx_carrier <= 1'b0;
        end else begin
            rx_clk_prev <= rx_clk_lvl;
            if (rx_rise) begin
                rx_lo_nib <= rx_nib;
                rx_ctl_rise <= rx_ctl;
            end else if (rx_fall) begin
                // error is the xor of the two control halves
                rx_word[1] <= rx_ctl_rise;
                rx_word[0] <= rx_ctl_rise ^ rx_ctl;
                if (speed == SPEED_GIG) begin
                    rx_word[9:2] <= {rx_nib, rx_lo_nib};
                end else begin
                    rx_word[9:2] <= {NIBBLE_RST, rx_lo_nib};
                end
                // idle halves carry link state in the nibble
                if (!rx_ctl_rise && !rx_ctl) begin
                    inband <= rx_lo_nib;
                end
                // valid or an error-only halves mean carrier
                rx_carrier <= rx_ctl_rise | rx_ctl;
            end
        end
    end

    // optional receive pipeline toward the mac
    logic [RXB_W-1:0] rx_piped;

    grc_pipe #(
        .WIDTH(RXB_W),
        .DEPTH(RX_PIPELINE_DEPTH)
    ) u_rx_pipe (
        .i_mclk(i_mclk),
        .i_srst(rx_rst),
        .i_data(rx_word),
        .o_data(rx_piped)
    );

    // collision needs half duplex, carrier and own transmission
    logic half_duplex;

    assign half_duplex = inband[STAT_LINK_BIT] & ~inband[STAT_DUPLEX_BIT];

    // mac-facing receive outputs, all from flip-flops
    always_ff @(posedge i_mclk) begin
        if (rx_rst) begin
            o_mac_rxd <= BYTE_RST;
            o_mac_rx_dv <= 1'b0;
            o_mac_rx_err <= 1'b0;
            o_mac_crs <= 1'b0;
            o_mac_col <= 1'b0;
            o_mac_rx_clock <= 1'b0;
        end else begin
            o_mac_rxd <= rx_piped[9:2];
            o_mac_rx_dv <= rx_piped[1];
            o_mac_rx_err <= rx_piped[0];
            o_mac_crs <= rx_carrier | tx_en_live;
            o_mac_col <= rx_carrier & tx_en_live & half_duplex;
            o_mac_rx_clock <= rx_clk_lvl;
        end
    end
endmodule : grc_converter

//--- rtl/grc_pkg.sv
package grc_pkg;
    // synchroniser length for every pin sampled by the system clock
    localparam int SYNC_STAGES = 2;
    // legal range and default of the optional pipelines
    localparam int MAX_PIPE_DEPTH = 10;
    localparam int DEF_PIPE_DEPTH = 0;
    // speed indication codes from the mac
    localparam logic [1:0] SPEED_TEN = 2'h0;
    localparam logic [1:0] SPEED_HUNDRED = 2'h1;
    localparam logic [1:0] SPEED_GIG = 2'h2;
    // widths of the two sides
    localparam int BYTE_W = 8;
    localparam int NIBBLE_W = 4;
    // field positions of the in-band status nibble
    localparam int STAT_LINK_BIT = 0;
    localparam int STAT_SPEED_LSB = 1;
    localparam int STAT_DUPLEX_BIT = 3;
    // reset values
    localparam logic [3:0] NIBBLE_RST = 4'h0;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [1:0] SPEED_RST = 2'h0;
    // transmit reference clocks
    typedef enum logic [1:0] {
        REF_GIG,
        REF_HUNDRED,
        REF_TEN
    } grc_ref_t;
    // glitch-free clock switch states
    typedef enum logic [1:0] {
        SW_RUN,
        SW_PARK
    } grc_sw_t;
endpackage : grc_pkg

//--- rtl/grc_pipe.sv
`timescale 1ns/1ns
// delay line of DEPTH register stages; depth zero is a plain wire
module grc_pipe
    import grc_pkg::*;
#(
    parameter int WIDTH = BYTE_W,
    parameter int DEPTH = DEF_PIPE_DEPTH
) (
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire logic [WIDTH-1:0] i_data,
    output logic [WIDTH-1:0] o_data
);
    // refuse depths the chain cannot build
    if (DEPTH < 0 || DEPTH > MAX_PIPE_DEPTH) begin : g_bad_depth
        $error("pipeline depth out of range");
    end

    // stage 0 is the input itself, stage DEPTH the output
    logic [WIDTH-1:0] stage [0:DEPTH];

    assign stage[0] = i_data;

    // one register per stage, cleared by reset
    for (genvar g = 0; g < DEPTH; g++) begin : g_stage
        always_ff @(posedge i_mclk) begin
            if (i_srst) begin
                stage[g+1] <= '0;
            end else begin
                stage[g+1] <= stage[g];
            end
        end
    end

    assign o_data = stage[DEPTH];
endmodule : grc_pipe

//--- sim/grc_converter_chk.sv
`timescale 1ns/1ns
// pin-level timing checks on the converter
module grc_converter_chk
    import grc_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire logic [1:0] i_mac_speed,
    input wire logic i_rgmii_rx_clock,
    input wire logic o_mac_tx_clock_return,
    input wire logic o_mac_rx_clock,
    input wire logic [7:0] o_mac_rxd,
    input wire logic o_mac_rx_dv,
    input wire logic o_mac_col,
    input wire logic o_mac_crs,
    input wire logic o_rgmii_tx_clock,
    input wire logic [3:0] o_rgmii_txd,
    input wire logic o_rgmii_tx_ctl
);
    default clocking dc @(posedge i_mclk);
    endclocking
    default disable iff (i_srst);
    // returned clock follows the line clock within a cycle
    a_txret_copy: assert property (
        $rose(o_rgmii_tx_clock) |-> ##[0:1] o_mac_tx_clock_return)
        else $error("tx clock return missed a rise");
    // data moves only with a clock edge, so no skew is added
    a_txd_hold: assert property (
        $stable(o_rgmii_tx_clock) |-> $stable(o_rgmii_txd))
        else $error("txd moved between clock edges");
    a_ctl_hold: assert property (
        $stable(o_rgmii_tx_clock) |-> $stable(o_rgmii_tx_ctl))
        else $error("tx ctl moved between clock edges");
    // each half lasts two cycles at least: no runt pulse
    a_high_no_runt: assert property (
        $rose(o_rgmii_tx_clock) |=> o_rgmii_tx_clock)
        else $error("runt high pulse on tx clock");
    a_low_no_runt: assert property (
        $fell(o_rgmii_tx_clock) |=> !o_rgmii_tx_clock)
        else $error("runt low pulse on tx clock");
    // a collision is only reported under carrier
    a_col_in_crs: assert property (o_mac_col |-> o_mac_crs)
        else $error("collision without carrier sense");
    // mac receive clock tracks the phy clock past the synchroniser
    a_rxclk_rise: assert property (
        $rose(i_rgmii_rx_clock) |-> ##[1:4] o_mac_rx_clock)
        else $error("rx clock rise not passed on");
    a_rxclk_fall: assert property (
        $fell(i_rgmii_rx_clock) |-> ##[1:4] !o_mac_rx_clock)
        else $error("rx clock fall not passed on");
    // first edge out of reset still shows quiet outputs
    a_quiet_reset: assert property (
        $fell(i_srst) |-> !o_rgmii_tx_clock && !o_mac_rx_dv
            && o_mac_rxd == BYTE_RST && !o_mac_crs)
        else $error("outputs busy right after reset");
    c_gig_tx: cover property ($rose(o_rgmii_tx_clock)
        && i_mac_speed == SPEED_GIG);
    c_rx_byte: cover property ($rose(o_mac_rx_dv));
    c_collision: cover property ($rose(o_mac_col));
endmodule : grc_converter_chk

bind grc_converter grc_converter_chk u_chk (
    .i_mclk, .i_srst, .i_mac_speed, .i_rgmii_rx_clock,
    .o_mac_tx_clock_return, .o_mac_rx_clock, .o_mac_rxd,
    .o_mac_rx_dv, .o_mac_col, .o_mac_crs, .o_rgmii_tx_clock,
    .o_rgmii_txd, .o_rgmii_tx_ctl
);

//--- sim/grc_phy_model.sv
`timescale 1ns/1ns
// phy stand-in: sends receive frames, decodes transmit halves
module grc_phy_model
    import grc_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_tx_clock,
    input wire logic [3:0] i_txd,
    input wire logic i_tx_ctl,
    output logic o_rx_clock,
    output logic [3:0] o_rxd,
    output logic o_rx_ctl,
    output logic [7:0] o_tx_byte,
    output logic o_tx_en,
    output logic o_tx_err,
    output logic [7:0] o_tx_count
);
    logic prev; // last sampled transmit clock
    logic [3:0] lo; // rising-half nibble
    logic rc; // rising-half control
    initial begin
        o_rx_clock = 1'b0; // clock stands still outside frames
        o_rxd = 4'h0;
        o_rx_ctl = 1'b0;
    end
    // one receive unit; data leads each clock edge by two cycles
    task automatic send(input logic [7:0] d, input logic en,
                        input logic er, input logic gig);
        @(posedge i_mclk);
        o_rxd <= d[3:0]; // low nibble rides the rising half
        o_rx_ctl <= en;
        repeat (2) @(posedge i_mclk);
        o_rx_clock <= 1'b1;
        repeat (3) @(posedge i_mclk);
        o_rxd <= gig ? d[7:4] : d[3:0];
        o_rx_ctl <= en ^ er;
        repeat (2) @(posedge i_mclk);
        o_rx_clock <= 1'b0;
        repeat (3) @(posedge i_mclk);
        // hold time over: lines must not keep a stale value
        o_rxd <= ~o_rxd;
        o_rx_ctl <= 1'b0;
    endtask : send
    // rebuild each transmit unit from its two halves
    // plain always: the unit count is seeded by the initial block below
    always @(posedge i_mclk) begin
        prev <= i_tx_clock;
        if (i_tx_clock && !prev) begin
            lo <= i_txd;
            rc <= i_tx_ctl;
        end
        if (!i_tx_clock && prev) begin
            o_tx_byte <= {i_txd, lo};
            o_tx_en <= rc;
            o_tx_err <= rc ^ i_tx_ctl;
            o_tx_count <= o_tx_count + 8'h01;
        end
    end
    initial o_tx_count = 8'h00;
endmodule : grc_phy_model

//--- sim/grc_converter_test.sv
`timescale 1ns/1ns
// converter bench: phy model on the line, bench as the mac
module grc_converter_test
    import grc_pkg::*;
;
    logic i_mclk = 1'b0, i_srst, i_mac_tx_rst_n, i_mac_rx_rst_n;
    // references start low; only the divider process drives them after
    logic i_mac_tx_clock = 1'b0, i_ref_clock_hundred_mbps = 1'b0;
    logic i_ref_clock_ten_mbps = 1'b0;
    logic [7:0] i_mac_txd;
    logic i_mac_tx_en, i_mac_tx_err;
    logic [1:0] i_mac_speed;
    logic i_rgmii_rx_clock, i_rgmii_rx_ctl;
    logic [3:0] i_rgmii_rxd, o_rgmii_txd;
    logic o_mac_tx_clock_return, o_mac_rx_clock, o_mac_rx_dv;
    logic o_mac_rx_err, o_mac_col, o_mac_crs, o_rgmii_tx_clock;
    logic o_rgmii_tx_ctl, tx_en, tx_err;
    logic [7:0] o_mac_rxd, tx_byte, tx_count;
    logic [4:0] tick = 5'h00; // free divider for the references
    logic [4:0] tick10 = 5'h00; // divider for the slow reference
    int failures = 0;
    int check_count = 0;
    always #5 i_mclk = ~i_mclk;
    // 25 MHz and 2.5 MHz references; gig reference slowed to 12.5 MHz
    always @(posedge i_mclk) begin
        tick <= tick + 5'h01;
        i_ref_clock_hundred_mbps <= tick[1];
        i_mac_tx_clock <= tick[2];
        tick10 <= (tick10 == 5'h13) ? 5'h00 : tick10 + 5'h01;
        if (tick10 == 5'h13) i_ref_clock_ten_mbps <= ~i_ref_clock_ten_mbps;
    end
    grc_converter #(.TX_PIPELINE_DEPTH(3), .RX_PIPELINE_DEPTH(2)) uut (
        .i_mclk, .i_srst, .i_mac_tx_clock, .i_ref_clock_hundred_mbps,
        .i_ref_clock_ten_mbps, .i_mac_tx_rst_n, .i_mac_rx_rst_n,
        .i_mac_txd, .i_mac_tx_en, .i_mac_tx_err, .i_mac_speed,
        .i_rgmii_rx_clock, .i_rgmii_rxd, .i_rgmii_rx_ctl,
        .o_mac_tx_clock_return, .o_mac_rx_clock, .o_mac_rxd,
        .o_mac_rx_dv, .o_mac_rx_err, .o_mac_col, .o_mac_crs,
        .o_rgmii_tx_clock, .o_rgmii_txd, .o_rgmii_tx_ctl
    );
    grc_phy_model phy (
        .i_mclk, .i_tx_clock(o_rgmii_tx_clock), .i_txd(o_rgmii_txd),
        .i_tx_ctl(o_rgmii_tx_ctl), .o_rx_clock(i_rgmii_rx_clock),
        .o_rxd(i_rgmii_rxd), .o_rx_ctl(i_rgmii_rx_ctl),
        .o_tx_byte(tx_byte), .o_tx_en(tx_en), .o_tx_err(tx_err),
        .o_tx_count(tx_count)
    );
    // compare one value, count it, report a mismatch at once
    task automatic chk(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp,
                     seen);
        end
    endtask : chk
    // let n transmit units pass; bounded so a dead clock cannot hang
    task automatic wait_tx(input int n);
        logic [7:0] start;
        int guard;
        start = tx_count;
        guard = 0;
        // eight-bit difference so a wrapped count still measures right
        while (8'(tx_count - start) < n && guard < 600) begin
            @(posedge i_mclk);
            guard++;
        end
        // a transmit clock that never came counts as a mismatch
        if (guard >= 600) begin
            failures++;
            $display("CHECK FAILED tx units expected %0d seen %0d", n,
                     8'(tx_count - start));
        end
    endtask : wait_tx
    // all rates in turn, switched live without any reset
    task automatic t_tx_rates();
        logic [1:0] spd [4] = '{SPEED_GIG, SPEED_GIG, SPEED_HUNDRED,
                                SPEED_TEN};
        logic [7:0] dat [4] = '{8'hA5, 8'h3C, 8'h96, 8'h5A};
        logic [7:0] exp;
        for (int i = 0; i < 4; i++) begin
            @(posedge i_mclk);
            i_mac_speed <= spd[i];
            i_mac_txd <= dat[i];
            i_mac_tx_en <= 1'b1;
            i_mac_tx_err <= (i == 1);
            wait_tx(4); // settle through the switch and the pipeline
            exp = (i < 2) ? dat[i] : {dat[i][3:0], dat[i][3:0]};
            chk("tx byte", tx_byte, exp);
            chk("tx enable", {7'h00, tx_en}, 8'h01);
            chk("tx error", {7'h00, tx_err},
                (i == 1) ? 8'h01 : 8'h00);
        end
        $display("test t_tx_rates done");
    endtask : t_tx_rates
    // gig receive: two nibbles make one byte, error from ctl halves
    task automatic t_rx_gig();
        @(posedge i_mclk);
        i_mac_tx_en <= 1'b0;
        i_mac_speed <= SPEED_GIG;
        phy.send(8'h3C, 1'b1, 1'b0, 1'b1);
        repeat (8) @(posedge i_mclk);
        chk("rx byte", o_mac_rxd, 8'h3C);
        chk("rx valid", {7'h00, o_mac_rx_dv}, 8'h01);
        chk("rx error", {7'h00, o_mac_rx_err}, 8'h00);
        chk("carrier", {7'h00, o_mac_crs}, 8'h01);
        phy.send(8'hE7, 1'b1, 1'b1, 1'b1);
        repeat (8) @(posedge i_mclk);
        chk("rx byte", o_mac_rxd, 8'hE7);
        chk("rx error", {7'h00, o_mac_rx_err}, 8'h01);
        $display("test t_rx_gig done");
    endtask : t_rx_gig
    // in-band status then a frame while transmitting: collision rule
    task automatic t_rx_status(input logic [7:0] stat, input logic col);
        @(posedge i_mclk);
        i_mac_tx_en <= 1'b0;
        i_mac_speed <= SPEED_HUNDRED;
        phy.send(stat, 1'b0, 1'b0, 1'b0); // idle halves carry status
        repeat (8) @(posedge i_mclk);
        chk("idle valid", {7'h00, o_mac_rx_dv}, 8'h00);
        chk("idle carrier", {7'h00, o_mac_crs}, 8'h00);
        i_mac_tx_en <= 1'b1;
        phy.send(8'hD7, 1'b1, 1'b0, 1'b0);
        repeat (8) @(posedge i_mclk);
        chk("mii byte", o_mac_rxd, 8'h07);
        chk("collision", {7'h00, o_mac_col}, {7'h00, col});
        $display("test t_rx_status done");
    endtask : t_rx_status
    // print the counts and the verdict, then stop
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : close_out
    // watchdog sized well past the longest expected run
    initial begin
        repeat (20000) @(posedge i_mclk);
        failures++;
        close_out();
    end
    initial begin
        i_srst = 1'b1;
        i_mac_tx_rst_n = 1'b0;
        i_mac_rx_rst_n = 1'b0;
        i_mac_txd = 8'h00;
        i_mac_tx_en = 1'b0;
        i_mac_tx_err = 1'b0;
        i_mac_speed = SPEED_GIG;
        repeat (12) @(posedge i_mclk);
        i_srst <= 1'b0;
        i_mac_tx_rst_n <= 1'b1;
        i_mac_rx_rst_n <= 1'b1;
        repeat (6) @(posedge i_mclk);
        t_tx_rates();
        t_rx_gig();
        t_rx_status(8'h03, 1'b1); // link up, half duplex
        t_rx_status(8'h0B, 1'b0); // link up, full duplex
        close_out();
    end
endmodule : grc_converter_test
